// [core/sink_drv_pkg.sv]
package sink_drv_pkg;

  // Stage count of the shift register and the holding latch
  localparam int unsigned STAGE_W = 8;

  // Width of the bundle of asynchronous input pins
  localparam int unsigned PIN_W = 5;

  // Clock and serial rate
  localparam longint unsigned CLK_FREQ_HZ     = 40_000_000;
  localparam longint unsigned MAX_BIT_RATE_HZ = 5_000_000;

  // Clock cycles per serial bit at the highest rate, rounded down
  localparam int unsigned CYCLES_PER_BIT =
    int'(CLK_FREQ_HZ / MAX_BIT_RATE_HZ);

  // Shortest high or low phase of the shift clock that is still seen
  localparam int unsigned MIN_PHASE_CYCLES = 3;

  // Reset values
  localparam logic [STAGE_W-1:0] STAGE_RESET = 8'h00;
  localparam logic [STAGE_W-1:0] LATCH_RESET = 8'h00;
  localparam logic [PIN_W-1:0]   PIN_RESET   = 5'h18;

  // Field positions inside the packed pin bundle
  localparam int unsigned PIN_DATA_POS  = 0;
  localparam int unsigned PIN_SHIFT_POS = 1;
  localparam int unsigned PIN_STROBE_POS = 2;
  localparam int unsigned PIN_CLEAR_POS = 3;
  localparam int unsigned PIN_OE_POS    = 4;

  // Host pins travelling together
  typedef struct packed {
    logic out_en_n;
    logic clear_n;
    logic strobe;
    logic shift_clk;
    logic ser_data;
  } pin_in_s;

endpackage

// [core/pin_sync.sv]
`timescale 1ns/100ps
module pin_sync #(
  parameter int unsigned           WIDTH = 1,
  parameter logic [WIDTH-1:0]      RESET = '0
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // Two flip-flop chain; the first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= RESET;
      sync_ff <= RESET;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule

// [core/serial_sink_driver.sv]
`timescale 1ns/100ps
module serial_sink_driver (
  // Clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              rst_n_i,
  // Host pins
  input  wire logic                              ser_data_i,
  input  wire logic                              shift_clk_i,
  input  wire logic                              strobe_i,
  input  wire logic                              clear_n_i,
  input  wire logic                              out_en_n_i,
  // Cascade output
  output logic                                   ser_data_o,
  // Open-drain sink outputs
  output logic [sink_drv_pkg::STAGE_W-1:0]       sink_drive_o,
  output logic [sink_drv_pkg::STAGE_W-1:0]       sink_drive_oe_o
);

  sink_drv_pkg::pin_in_s                 pin_raw;
  sink_drv_pkg::pin_in_s                 pin_s;
  logic [sink_drv_pkg::PIN_W-1:0]        pin_sync_vec;

  logic [sink_drv_pkg::STAGE_W-1:0]      shift_ff;
  logic [sink_drv_pkg::STAGE_W-1:0]      nxt_shift;
  logic [sink_drv_pkg::STAGE_W-1:0]      latch_ff;
  logic [sink_drv_pkg::STAGE_W-1:0]      nxt_latch;
  logic [sink_drv_pkg::STAGE_W-1:0]      drive_oe_ff;
  logic [sink_drv_pkg::STAGE_W-1:0]      nxt_drive_oe;
  logic [sink_drv_pkg::STAGE_W-1:0]      drive_lvl_ff;
  logic                                  ser_out_ff;

  logic                                  shift_prev_ff;
  logic                                  strobe_prev_ff;
  wire logic                             shift_rise;
  wire logic                             strobe_rise;
  wire logic                             clear_act;
  wire logic                             blank_act;

  // Rising edge of a synchronised level
  function automatic logic rise_of(input logic now_v, input logic prev_v);
    rise_of = now_v & ~prev_v;
  endfunction

  // Pins gathered and passed through the synchroniser
  assign pin_raw.ser_data  = ser_data_i;
  assign pin_raw.shift_clk = shift_clk_i;
  assign pin_raw.strobe    = strobe_i;
  assign pin_raw.clear_n   = clear_n_i;
  assign pin_raw.out_en_n  = out_en_n_i;

  pin_sync #(
    .WIDTH (sink_drv_pkg::PIN_W),
    .RESET (sink_drv_pkg::PIN_RESET)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (pin_raw),
    .sync_o  (pin_sync_vec)
  );

  assign pin_s = pin_sync_vec;

  // Edge detection on synchronised shift clock and strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_prev_ff  <= 1'b0;
      strobe_prev_ff <= 1'b0;
    end else begin
      shift_prev_ff  <= pin_s.shift_clk;
      strobe_prev_ff <= pin_s.strobe;
    end
  end

  // Each edge seen within a few clocks of the pin, well inside one bit
  assign shift_rise  = rise_of(pin_s.shift_clk, shift_prev_ff);
  assign strobe_rise = rise_of(pin_s.strobe, strobe_prev_ff);
  assign clear_act   = ~pin_s.clear_n;
  assign blank_act   = pin_s.out_en_n;

  // Next shift contents
  assign nxt_shift = clear_act   ? sink_drv_pkg::STAGE_RESET :
                     shift_rise  ? {shift_ff[sink_drv_pkg::STAGE_W-2:0],
                                    pin_s.ser_data} :
                     shift_ff;

  // Next latch contents
  assign nxt_latch = clear_act   ? sink_drv_pkg::LATCH_RESET :
                     strobe_rise ? shift_ff :
                     latch_ff;

  // Sink enable per output: on for a one bit, blanked when disabled
  assign nxt_drive_oe = blank_act ? '0 : latch_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_ff <= sink_drv_pkg::STAGE_RESET;
      latch_ff <= sink_drv_pkg::LATCH_RESET;
    end else begin
      shift_ff <= nxt_shift;
      latch_ff <= nxt_latch;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_oe_ff  <= '0;
      drive_lvl_ff <= '0;
      ser_out_ff   <= 1'b0;
    end else begin
      drive_oe_ff  <= nxt_drive_oe;
      drive_lvl_ff <= '0;
      ser_out_ff   <= nxt_shift[sink_drv_pkg::STAGE_W-1];
    end
  end

  assign ser_data_o      = ser_out_ff;
  assign sink_drive_o    = drive_lvl_ff;
  assign sink_drive_oe_o = drive_oe_ff;

  // Shift moves every stage by one on a clock edge
  shift_move_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    shift_rise && !clear_act |=>
      shift_ff == {$past(shift_ff[sink_drv_pkg::STAGE_W-2:0]),
                   $past(pin_s.ser_data)})
    else $error("shift did not advance by one stage");

  // Stage k takes old stage k-1
  stage_chain_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    shift_rise && !clear_act |=>
      shift_ff[sink_drv_pkg::STAGE_W-1:1] ==
      $past(shift_ff[sink_drv_pkg::STAGE_W-2:0]))
    else $error("stage chain broken");

  // Stages stay put without a shift edge
  shift_hold_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !shift_rise && !clear_act |=> $stable(shift_ff))
    else $error("shift stages moved without an edge");

  // Strobe copies all stages into the latch
  latch_load_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    strobe_rise && !clear_act |=> latch_ff == $past(shift_ff))
    else $error("latch did not load the stages");

  // Latch holds between strobes
  latch_hold_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !strobe_rise && !clear_act |=> $stable(latch_ff))
    else $error("latch changed without a strobe");

  // Clear zeroes the stages and the latch even while shifting
  clear_zero_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    clear_act |=> shift_ff == '0 && latch_ff == '0)
    else $error("clear left a register set");

  // Blanking forces every sink off, held for the whole blank
  blank_off_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    blank_act [*2] |=> sink_drive_oe_o == '0 && sink_drive_o == '0)
    else $error("sink driven while blanked");

  // Enabled sinks follow the latch, one bit on means sinking
  drive_follow_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !blank_act |=> sink_drive_oe_o == $past(latch_ff))
    else $error("sinks do not follow the latch");

  // Serial output carries the newest last stage
  serial_out_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    shift_rise && !clear_act |=>
      ser_data_o == $past(shift_ff[sink_drv_pkg::STAGE_W-2]))
    else $error("serial output not the last stage");

  // A shift edge is a single pulse, so one bit shifts once
  shift_pulse_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    shift_rise |=> !shift_rise)
    else $error("shift edge lasted more than a cycle");

  // Blanking turns every sink off on the next edge
  blank_fast_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    blank_act |=> sink_drive_oe_o == '0)
    else $error("sink still on after blanking");

  // Open-drain level never drives high
  sink_level_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    sink_drive_o == '0)
    else $error("sink level not low");

  // Serial output always mirrors the last stage
  serial_tail_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ser_data_o == shift_ff[sink_drv_pkg::STAGE_W-1])
    else $error("serial output differs from last stage");

  // Clear wins over a shift edge in the same cycle
  clear_first_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    clear_act && shift_rise |=> shift_ff == '0 && ser_data_o == 1'b0)
    else $error("shift got past an active clear");

  // Every synchronised shift clock rise is taken
  edge_seen_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(pin_s.shift_clk) |-> shift_rise)
    else $error("shift clock edge missed");

  // A strobe edge loads the latch only once
  strobe_pulse_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    strobe_rise |=> !strobe_rise)
    else $error("strobe edge lasted more than a cycle");

endmodule

// [testbench/sink_host_model.sv]
`timescale 1ns/100ps
module sink_host_model (
  // Clock
  input  wire logic clk_i,
  // Host pins
  output logic      ser_data_o,
  output logic      shift_clk_o,
  output logic      strobe_o,
  output logic      clear_n_o,
  output logic      out_en_n_o
);
  // Idle levels: blanked, not clearing, both clocks low
  initial begin
    {out_en_n_o, clear_n_o, strobe_o, shift_clk_o, ser_data_o} =
      sink_drv_pkg::PIN_RESET;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Eight clocks a bit, data inverted once the hold has run out
  task automatic send_bit(input logic b);
    ser_data_o <= b;
    wait_clk(3);
    shift_clk_o <= 1'b1;
    wait_clk(4);
    shift_clk_o <= 1'b0;
    ser_data_o <= ~b;
    wait_clk(1);
  endtask

  // Most significant bit first
  task automatic send_byte(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      send_bit(d[i]);
    end
  endtask

  task automatic strobe_latch();
    strobe_o <= 1'b1;
    wait_clk(4);
    strobe_o <= 1'b0;
    wait_clk(4);
  endtask

  task automatic set_oe_n(input logic v);
    out_en_n_o <= v;
    wait_clk(1);
  endtask

  task automatic set_clear_n(input logic v);
    clear_n_o <= v;
    wait_clk(1);
  endtask
endmodule

// [testbench/test_serial_sink_driver.sv]
`timescale 1ns/100ps
module test_serial_sink_driver;
  typedef struct packed {
    logic [7:0] data;
    logic       oe_n;
    logic [7:0] exp;
  } row_s;

  logic                   clk_i;
  logic                   rst_n_i;
  logic                   ser_data_i;
  logic                   shift_clk_i;
  logic                   strobe_i;
  logic                   clear_n_i;
  logic                   out_en_n_i;
  logic                   ser_data_o;
  logic [7:0]             sink_drive_o;
  logic [7:0]             sink_drive_oe_o;
  int                     error_cnt = 0;
  int                     checks_done = 0;
  row_s                   rows [4] = '{'{8'hA5, 1'b0, 8'hA5},
    '{8'h3C, 1'b0, 8'h3C}, '{8'hFF, 1'b1, 8'h00}, '{8'h01, 1'b0, 8'h01}};

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  sink_host_model host_u (
    .clk_i       (clk_i),
    .ser_data_o  (ser_data_i),
    .shift_clk_o (shift_clk_i),
    .strobe_o    (strobe_i),
    .clear_n_o   (clear_n_i),
    .out_en_n_o  (out_en_n_i)
  );

  serial_sink_driver dut_u (
    .clk_i           (clk_i),
    .rst_n_i         (rst_n_i),
    .ser_data_i      (ser_data_i),
    .shift_clk_i     (shift_clk_i),
    .strobe_i        (strobe_i),
    .clear_n_i       (clear_n_i),
    .out_en_n_i      (out_en_n_i),
    .ser_data_o      (ser_data_o),
    .sink_drive_o    (sink_drive_o),
    .sink_drive_oe_o (sink_drive_oe_o)
  );

  task automatic check_vec(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: sinks %h, want %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: serial out %b, want %b", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    rst_n_i <= 1'b0;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    host_u.wait_clk(4);
    check_vec(sink_drive_oe_o, 8'h00);
    check_bit(ser_data_o, 1'b0);
    $display("test reset done");
    foreach (rows[i]) begin
      host_u.send_byte(rows[i].data);
      host_u.strobe_latch();
      host_u.set_oe_n(rows[i].oe_n);
      host_u.wait_clk(4);
      check_vec(sink_drive_oe_o, rows[i].exp);
      check_bit(ser_data_o, rows[i].data[7]);
      check_vec(sink_drive_o, 8'h00);
    end
    $display("test rows done");
    host_u.send_byte(8'h70);
    check_vec(sink_drive_oe_o, 8'h01);
    check_bit(ser_data_o, 1'b0);
    host_u.send_bit(1'b0);
    host_u.wait_clk(3);
    check_bit(ser_data_o, 1'b1);
    host_u.strobe_latch();
    check_vec(sink_drive_oe_o, 8'hE0);
    $display("test hold done");
    host_u.set_clear_n(1'b0);
    host_u.wait_clk(4);
    check_vec(sink_drive_oe_o, 8'h00);
    check_bit(ser_data_o, 1'b0);
    host_u.send_byte(8'hFF);
    host_u.set_clear_n(1'b1);
    host_u.strobe_latch();
    check_vec(sink_drive_oe_o, 8'h00);
    check_bit(ser_data_o, 1'b0);
    $display("test clear done");
    host_u.send_byte(8'hAA);
    host_u.strobe_latch();
    check_vec(sink_drive_oe_o, 8'hAA);
    rst_n_i <= 1'b0;
    host_u.wait_clk(2);
    check_vec(sink_drive_oe_o, 8'h00);
    check_bit(ser_data_o, 1'b0);
    rst_n_i <= 1'b1;
    host_u.wait_clk(4);
    check_vec(sink_drive_oe_o, 8'h00);
    check_bit(ser_data_o, 1'b0);
    host_u.send_byte(8'h81);
    host_u.strobe_latch();
    check_vec(sink_drive_oe_o, 8'h81);
    check_bit(ser_data_o, 1'b1);
    $display("test second reset done");
    host_u.send_byte(8'h3C);
    fork
      host_u.send_bit(1'b1);
      begin
        host_u.wait_clk(3);
        host_u.strobe_latch();
      end
    join
    check_vec(sink_drive_oe_o, 8'h3C);
    host_u.strobe_latch();
    check_vec(sink_drive_oe_o, 8'h79);
    check_bit(ser_data_o, 1'b0);
    $display("test same edge done");
    tally_and_finish();
  end
endmodule
